// [verilog/tbm_pkg.sv]
package tbm_pkg;
  // ----------------------------------------------------------------
  // Register map (word indexes, byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 18;
  localparam logic [15:0] IDX_SLOT_FIRST = 16'hF300;
  localparam logic [15:0] IDX_SLOT_LAST = 16'hF33F;
  localparam logic [15:0] IDX_CTRL = 16'hF340;
  localparam logic [15:0] IDX_STAT = 16'hF341;
  localparam logic [15:0] IDX_FRAMES = 16'hF342;
  localparam logic [2:0] DEC_SLOT = 3'h0;
  localparam logic [2:0] DEC_CTRL = 3'h1;
  localparam logic [2:0] DEC_STAT = 3'h2;
  localparam logic [2:0] DEC_FRAMES = 3'h3;
  localparam logic [2:0] DEC_NONE = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // ----------------------------------------------------------------
  // Slot register fields
  // ----------------------------------------------------------------
  localparam int SLOTS = 64;
  localparam int CHANS = 16;
  localparam int SLOT_EN = 7;
  localparam int SLOT_REV = 6;
  localparam int SLOT_SEL = 5;
  localparam int POS_HI = 4;
  localparam int POS_LO = 2;
  localparam int BYTE_HI = 1;
  localparam int BYTE_LO = 0;
  localparam logic [7:0] SLOT_RST = 8'h00;
  localparam logic [5:0] CH_BASE = 6'h20;
  // Control and status bits
  localparam int CTRL_EN = 0;
  localparam int CTRL_CLR_OVR = 1;
  localparam int STAT_OVR = 0;
  localparam int STAT_BUSY = 1;
  localparam int STAT_ACTIVE = 2;
  localparam int FIFO_DEPTH = 16;

  typedef struct packed {
    logic [5:0] chan;
    logic [31:0] data;
  } tbm_word_t;

  typedef struct packed {
    logic frame;
    logic byte_done;
    logic [4:0] slot;
    logic [7:0] a;
    logic [7:0] b;
  } tbm_rx_t;
endpackage

// [verilog/tbm_fifo.sv]
`timescale 1ns/1ns
`default_nettype none
module tbm_fifo #(
  parameter int WIDTH = 38,
  parameter int DEPTH = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("tbm_fifo depth must be a power of two");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
    logic ov;
    logic [WIDTH-1:0] od;
  } tbm_fifo_state_t;

  tbm_fifo_state_t r;
  tbm_fifo_state_t next_r;
  logic push;
  logic pop;

  // Output word sits in its own register so the consumer sees a flop
  always_comb
  begin
    next_r = r;
    push = in_valid && (r.cnt != CW'(DEPTH));
    pop = (r.cnt != '0) && (!r.ov || out_ready);
    if (push)
    begin
      next_r.mem[r.wp] = in_data;
      next_r.wp = r.wp + 1'b1;
    end
    if (pop)
    begin
      next_r.od = r.mem[r.rp];
      next_r.rp = r.rp + 1'b1;
      next_r.ov = 1'b1;
    end
    else if (out_ready)
    begin
      next_r.ov = 1'b0;
    end
    next_r.cnt = r.cnt + CW'(push) - CW'(pop);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      r <= '0;
    else
      r <= next_r;
  end

  assign in_ready = (r.cnt != CW'(DEPTH));
  assign out_valid = r.ov;
  assign out_data = r.od;
endmodule
`default_nettype wire

// [verilog/tbm_rx.sv]
`timescale 1ns/1ns
`default_nettype none
module tbm_rx (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic en,
  input wire logic bclk,
  input wire logic fsync,
  input wire logic pin_a,
  input wire logic pin_b,
  output tbm_pkg::tbm_rx_t rx_out
);
  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic fs_last;
    logic run;
    logic [7:0] cnt;
    logic [7:0] sa;
    logic [7:0] sb;
    tbm_pkg::tbm_rx_t out;
  } tbm_rx_state_t;

  tbm_rx_state_t r;
  tbm_rx_state_t next_r;
  logic [7:0] bit_idx;
  logic start;

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  // Bits are sampled on the bit clock rising edge; the frame opens on
  // the first edge that sees sync high after it was low.
  always_comb
  begin
    next_r = r;
    next_r.out.frame = 1'b0;
    next_r.out.byte_done = 1'b0;
    next_r.s1 = {fsync, bclk, pin_b, pin_a};
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    start = 1'b0;
    bit_idx = r.cnt;
    if (r.s2[2] && !r.s3[2])
    begin
      next_r.fs_last = r.s3[3];
      start = en && r.s3[3] && !r.fs_last;
      bit_idx = start ? 8'h00 : r.cnt;
      next_r.sa = {r.sa[6:0], r.s3[0]};
      next_r.sb = {r.sb[6:0], r.s3[1]};
      if (start || r.run)
      begin
        next_r.out.frame = start;
        next_r.cnt = bit_idx + 8'h01;
        next_r.run = (bit_idx != 8'hFF);
        if (bit_idx[2:0] == 3'h7)
        begin
          next_r.out.byte_done = 1'b1;
          next_r.out.slot = bit_idx[7:3];
          next_r.out.a = next_r.sa;
          next_r.out.b = next_r.sb;
        end
      end
    end
    if (!en)
      next_r.run = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      r <= '0;
    else
      r <= next_r;
  end

  assign rx_out = r.out;
endmodule
`default_nettype wire

// [verilog/tbm_mapper.sv]
// Summary of operation
// R1: 64 slot registers build 16 input channels
// R2: Enable bit set accepts slot, clear ignores
// R3: Reverse bit flips byte bit order
// R4: Select bit picks first or second pin
// R5: Select bit picks channels 32-39 or 40-47
// R6: Position field adds 0..7 to group base
// R7: Byte field picks channel byte, 00 topmost
// R8: Slot registers at consecutive word indexes
// R9: Slot registers reset zero, upper byte reserved
// R10: Last received wins, untargeted bytes zero
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module tbm_mapper #(
  parameter int FIFO_DEPTH = tbm_pkg::FIFO_DEPTH
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [17:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [17:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tdm_bclk,
  input wire logic tdm_fsync,
  input wire logic tdm_input_pin_a,
  input wire logic tdm_input_pin_b,
  output logic m_valid,
  input wire logic m_ready,
  output tbm_pkg::tbm_word_t m_word
);
  if (FIFO_DEPTH < tbm_pkg::CHANS)
  begin : g_bad_depth
    $error("tbm_mapper fifo must hold one whole frame");
  end

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_DUMP = 2'b10
  } tbm_state_t;

  typedef struct packed {
    logic [tbm_pkg::SLOTS-1:0][7:0] slot;
    logic [tbm_pkg::CHANS-1:0][31:0] acc;
    logic [tbm_pkg::CHANS-1:0][31:0] snap;
    logic have;
    tbm_state_t st;
    logic [3:0] idx;
    logic en;
    logic ovr;
    logic [31:0] frames;
    logic aw_got;
    logic [15:0] aw_idx;
    logic w_got;
    logic [7:0] w_byte;
    logic w_lane0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tbm_top_state_t;

  tbm_top_state_t r;
  tbm_top_state_t next_r;
  tbm_pkg::tbm_rx_t rx;
  tbm_pkg::tbm_word_t push_word;
  logic push_valid;
  logic push_ready;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] decode(input logic [15:0] idx);
    logic [2:0] kind;
    kind = tbm_pkg::DEC_NONE;
    if (idx >= tbm_pkg::IDX_SLOT_FIRST && idx <= tbm_pkg::IDX_SLOT_LAST) // R8
      kind = tbm_pkg::DEC_SLOT;
    else if (idx == tbm_pkg::IDX_CTRL)
      kind = tbm_pkg::DEC_CTRL;
    else if (idx == tbm_pkg::IDX_STAT)
      kind = tbm_pkg::DEC_STAT;
    else if (idx == tbm_pkg::IDX_FRAMES)
      kind = tbm_pkg::DEC_FRAMES;
    return kind;
  endfunction

  function automatic logic [7:0] reverse8(input logic [7:0] d);
    logic [7:0] o;
    o = '0;
    for (int i = 0; i < 8; i++)
    begin
      o[i] = d[7-i];
    end
    return o;
  endfunction

  // ----------------------------------------------------------------
  // Serial front end and output buffer
  // ----------------------------------------------------------------
  tbm_rx u_rx (
    .aclk(aclk),
    .aresetn(aresetn),
    .en(r.en),
    .bclk(tdm_bclk),
    .fsync(tdm_fsync),
    .pin_a(tdm_input_pin_a),
    .pin_b(tdm_input_pin_b),
    .rx_out(rx)
  );

  // A full buffer stalls the frame dump; a frame that ends while the
  // previous one is still draining is dropped and flagged.
  tbm_fifo #(
    .WIDTH($bits(tbm_pkg::tbm_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_word),
    .out_valid(m_valid),
    .out_ready(m_ready),
    .out_data(m_word)
  );

  assign push_valid = (r.st == ST_DUMP);
  assign push_word.chan = tbm_pkg::CH_BASE + {2'b00, r.idx};
  assign push_word.data = r.snap[r.idx];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [7:0] cfg;
    logic [7:0] val;
    logic [3:0] dest;
    logic [4:0] lane;
    logic [15:0] ar_idx;
    logic [2:0] kind;
    cfg = '0;
    val = '0;
    dest = '0;
    lane = '0;
    ar_idx = s_axi_araddr[17:2];
    kind = tbm_pkg::DEC_NONE;
    next_r = r;

    // Frame boundary: hand the finished frame to the dump, start clean
    if (rx.frame)
    begin
      if (r.have)
      begin
        if (r.st == ST_DUMP)
        begin
          next_r.ovr = 1'b1;
        end
        else
        begin
          next_r.snap = r.acc;
          next_r.st = ST_DUMP;
          next_r.idx = '0;
          next_r.frames = r.frames + 32'h0000_0001;
        end
      end
      next_r.have = 1'b1;
      next_r.acc = '0; // R10
    end

    // Each stream byte slot k is served by registers k and k+32
    if (rx.byte_done)
    begin
      for (int p = 0; p < 2; p++)
      begin
        for (int j = 0; j < 2; j++)
        begin
          cfg = r.slot[{j[0], rx.slot}]; // R1
          if (cfg[tbm_pkg::SLOT_EN] && (cfg[tbm_pkg::SLOT_SEL] == p[0])) // R2 R4
          begin
            val = (p == 0) ? rx.a : rx.b;
            if (cfg[tbm_pkg::SLOT_REV]) // R3
              val = reverse8(val);
            dest = {cfg[tbm_pkg::SLOT_SEL], cfg[tbm_pkg::POS_HI:tbm_pkg::POS_LO]}; // R5 R6
            lane = {~cfg[tbm_pkg::BYTE_HI:tbm_pkg::BYTE_LO], 3'b000}; // R7
            next_r.acc[dest][lane +: 8] = val; // R10
          end
        end
      end
    end

    // Drain the snapshot into the buffer, channel 32 first
    case (r.st)
      ST_IDLE:
      begin
        next_r.idx = r.idx;
      end
      ST_DUMP:
      begin
        if (push_ready)
        begin
          next_r.idx = r.idx + 4'h1;
          if (r.idx == 4'hF)
            next_r.st = ST_IDLE;
        end
      end
      default:
      begin
        next_r.st = ST_IDLE;
      end
    endcase

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && r.awready)
    begin
      next_r.aw_got = 1'b1;
      next_r.aw_idx = s_axi_awaddr[17:2];
    end
    if (s_axi_wvalid && r.wready)
    begin
      next_r.w_got = 1'b1;
      next_r.w_byte = s_axi_wdata[7:0];
      next_r.w_lane0 = s_axi_wstrb[0];
    end
    if (r.aw_got && r.w_got && !r.bvalid)
    begin
      kind = decode(r.aw_idx);
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = tbm_pkg::RESP_OKAY;
      if (kind == tbm_pkg::DEC_SLOT && r.w_lane0)
      begin
        next_r.slot[r.aw_idx[5:0]] = r.w_byte; // R8
      end
      else if (kind == tbm_pkg::DEC_CTRL && r.w_lane0)
      begin
        next_r.en = r.w_byte[tbm_pkg::CTRL_EN];
        // A new overrun in this cycle beats the clear
        if (r.w_byte[tbm_pkg::CTRL_CLR_OVR] && !(rx.frame && r.have && r.st == ST_DUMP))
          next_r.ovr = 1'b0;
      end
      else if (kind == tbm_pkg::DEC_NONE)
      begin
        next_r.bresp = tbm_pkg::RESP_DECERR;
      end
    end
    else if (r.bvalid && s_axi_bready)
    begin
      next_r.bvalid = 1'b0;
    end
    next_r.awready = !next_r.aw_got && !next_r.bvalid;
    next_r.wready = !next_r.w_got && !next_r.bvalid;

    // Read channel: one cycle from address to data
    if (s_axi_arvalid && r.arready)
    begin
      kind = decode(ar_idx);
      next_r.arready = 1'b0;
      next_r.rvalid = 1'b1;
      next_r.rresp = tbm_pkg::RESP_OKAY;
      next_r.rdata = 32'h0000_0000;
      case (kind)
        tbm_pkg::DEC_SLOT:
          next_r.rdata[7:0] = r.slot[ar_idx[5:0]]; // R9
        tbm_pkg::DEC_CTRL:
          next_r.rdata[tbm_pkg::CTRL_EN] = r.en;
        tbm_pkg::DEC_STAT:
        begin
          next_r.rdata[tbm_pkg::STAT_OVR] = r.ovr;
          next_r.rdata[tbm_pkg::STAT_BUSY] = (r.st == ST_DUMP);
          next_r.rdata[tbm_pkg::STAT_ACTIVE] = r.have;
        end
        tbm_pkg::DEC_FRAMES:
          next_r.rdata = r.frames;
        default:
          next_r.rresp = tbm_pkg::RESP_DECERR;
      endcase
    end
    else if (r.rvalid && s_axi_rready)
    begin
      next_r.rvalid = 1'b0;
      next_r.arready = 1'b1;
    end
    else if (!r.rvalid)
    begin
      next_r.arready = 1'b1;
    end

    // Disabling stops accumulation; the next frame starts fresh
    if (!r.en)
      next_r.have = 1'b0;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r <= '0; // R9
      r.st <= ST_IDLE;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
endmodule
`default_nettype wire

// [testbench/tbm_mapper_sva.sv]
`timescale 1ns/1ns
`default_nettype none
module tbm_mapper_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [17:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic m_valid,
  input wire logic m_ready,
  input wire tbm_pkg::tbm_word_t m_word
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Channel that the next output word must carry; a dump always runs 32..47
  logic [5:0] exp_chan;
  always_ff @(posedge aclk)
    if (!aresetn)
      exp_chan <= 6'h20;
    else if (m_valid && m_ready)
      exp_chan <= (exp_chan == 6'h2F) ? 6'h20 : exp_chan + 6'h01;
  // Only slot registers are one byte wide; the frame counter fills the whole word
  logic rd_slot;
  always_ff @(posedge aclk)
    if (!aresetn)
      rd_slot <= 1'b0;
    else if (s_axi_arvalid && s_axi_arready)
      rd_slot <= (s_axi_araddr[17:8] == tbm_pkg::IDX_SLOT_FIRST[15:6]);
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  wr_answer_a: assert property (aw_w_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  rd_answer_a: assert property (ar_taken |=> s_axi_rvalid)
    else $error("read response missing");
  ar_refuse_a: assert property (ar_taken |=> !s_axi_arready)
    else $error("read address taken while read pending");
  bresp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h3})
    else $error("write response code illegal");
  decerr_data_a: assert property (s_axi_rvalid && s_axi_rresp != 2'h0 |->
    s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0000_0000)
    else $error("bad read error response");
  resv_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h0 && rd_slot |->
    s_axi_rdata[31:8] == 24'h00_0000)
    else $error("reserved read bits not zero");
  word_hold_a: assert property (m_valid && !m_ready |=> m_valid && $stable(m_word))
    else $error("output word dropped or changed while stalled");
  chan_range_a: assert property (m_valid |-> m_word.chan inside {[6'h20:6'h2F]})
    else $error("output channel out of range");
  chan_order_a: assert property (m_valid |-> m_word.chan == exp_chan)
    else $error("output channel out of order");
endmodule
bind tbm_mapper tbm_mapper_sva i_sva (.*);
`default_nettype wire

// [testbench/tbm_tdm_src.sv]
`timescale 1ns/1ns
`default_nettype none
module tbm_tdm_src (
  input wire logic aclk,
  output logic bclk,
  output logic fsync,
  output logic pin_a,
  output logic pin_b
);
  initial
  begin
    bclk = 1'b0;
    fsync = 1'b0;
    pin_a = 1'b0;
    pin_b = 1'b0;
  end
  // Bit clock of eight aclk periods keeps well under the receiver's limit
  task automatic bit_out(input logic s, input logic a, input logic b);
    fsync <= s;
    pin_a <= a;
    pin_b <= b;
    repeat (4) @(posedge aclk);
    bclk <= 1'b1;
    repeat (4) @(posedge aclk);
    bclk <= 1'b0;
  endtask
  // One idle bit ahead so that the sync is always seen rising from low
  task automatic send(input logic [255:0] a, input logic [255:0] b);
    bit_out(1'b0, ~pin_a, ~pin_b);
    for (int i = 0; i < 256; i++)
      bit_out(i == 0, a[255 - i], b[255 - i]);
    fsync <= 1'b0;
    pin_a <= ~a[0];
    pin_b <= ~b[0];
  endtask
endmodule
`default_nettype wire

// [testbench/tb_tbm_mapper.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_tbm_mapper;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [17:0] s_axi_awaddr = '0;
  logic [2:0] s_axi_awprot = '0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [17:0] s_axi_araddr = '0;
  logic [2:0] s_axi_arprot = '0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic tdm_bclk, tdm_fsync, tdm_input_pin_a, tdm_input_pin_b;
  logic m_valid;
  logic m_ready = 1'b0;
  tbm_pkg::tbm_word_t m_word;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int got_n = 0;
  logic [7:0] slot [64];
  logic [7:0] fa [32];
  logic [7:0] fb [32];
  logic [37:0] exp_q [$];
  logic [255:0] pa, pb;

  tbm_mapper i_dut (.*);
  tbm_tdm_src i_src (.aclk(aclk), .bclk(tdm_bclk), .fsync(tdm_fsync),
    .pin_a(tdm_input_pin_a), .pin_b(tdm_input_pin_b));

  always #20 aclk = ~aclk;
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [63:0] g, input logic [63:0] e);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic final_report();
    if (bad_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // One edge first, so a back-to-back call never re-raises bready in the step that dropped it
  task automatic wr(input logic [15:0] idx, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (1)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (1)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Later slot wins; within one stream slot register k+32 beats k
  task automatic model();
    logic [31:0] w [16];
    logic [7:0] c, v;
    for (int i = 0; i < 16; i++) w[i] = '0;
    for (int k = 0; k < 32; k++)
      for (int j = 0; j < 2; j++)
      begin
        c = slot[k + 32 * j];
        v = c[5] ? fb[k] : fa[k];
        if (c[6]) v = {<<{v}};
        if (c[7]) w[{c[5], c[4:2]}][31 - 8 * c[1:0] -: 8] = v;
      end
    for (int i = 0; i < 16; i++) exp_q.push_back({6'(32 + i), w[i]});
  endtask
  // ----------------------------------------------------------------
  // Output collector with random stalls, and hang guard
  // ----------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (aresetn && m_valid && m_ready)
    begin
      got_n++;
      check(64'({m_word.chan, m_word.data}), exp_q.size() ? 64'(exp_q.pop_front()) : {64{1'bx}});
    end
    m_ready <= ($urandom_range(0, 3) != 0);
  end
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      final_report();
    end
  end
  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    void'($urandom(60312));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(16'hF300, d, r);
    check(64'(d), 64'h0);
    rd(16'hF33F, d, r);
    check(64'(d), 64'h0);
    rd(16'hF343, d, r);
    check(64'(r), 64'(tbm_pkg::RESP_DECERR));
    wr(16'hF2FF, 32'h0000_0080, r);
    check(64'(r), 64'(tbm_pkg::RESP_DECERR));
    for (int i = 0; i < 64; i++)
    begin
      d = $urandom;
      slot[i] = d[7:0];
      wr(tbm_pkg::IDX_SLOT_FIRST + 16'(i), d, r);
      check(64'(r), 64'(tbm_pkg::RESP_OKAY));
    end
    for (int i = 0; i < 64; i++)
    begin
      rd(tbm_pkg::IDX_SLOT_FIRST + 16'(i), d, r);
      check(64'(d), 64'({24'h00_0000, slot[i]}));
    end
    wr(tbm_pkg::IDX_CTRL, 32'h0000_0001, r);
    for (int f = 0; f < 4; f++)
    begin
      for (int k = 0; k < 32; k++)
      begin
        fa[k] = 8'($urandom);
        fb[k] = 8'($urandom);
        pa[255 - 8 * k -: 8] = fa[k];
        pb[255 - 8 * k -: 8] = fb[k];
      end
      // The last frame only closes the one before it
      if (f < 3) model();
      i_src.send(pa, pb);
    end
    while (exp_q.size() != 0) @(posedge aclk);
    repeat (20) @(posedge aclk);
    check(64'(got_n), 64'd48);
    rd(tbm_pkg::IDX_FRAMES, d, r);
    check(64'(d), 64'h3);
    final_report();
  end
endmodule
`default_nettype wire
